// ===== include/ceiu_pkg.sv
// Purpose: shared constants of the codec error interrupt unit
// Assumes: 10 MHz core clock, byte addresses on the register bus
// Notes:   one aligned 32-bit word per register
package ceiu_pkg;
  // ----------------------------------------------------------------
  // error sources and their bit positions
  // ----------------------------------------------------------------
  localparam int unsigned NCH      = 4;
  localparam int unsigned NSRC     = 11;
  localparam int unsigned ERR_TEST = 0;
  localparam int unsigned ERR_SP   = 1;
  localparam int unsigned ERR_CLK  = 2;
  localparam int unsigned ERR_ADC  = 3;
  localparam int unsigned ERR_DAC  = 7;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned AW       = 5;
  localparam int unsigned DW       = 32;
  localparam logic [4:0]  OFS_STAT = 5'h00;
  localparam logic [4:0]  OFS_MASK = 5'h04;
  localparam logic [4:0]  OFS_CTRL = 5'h08;
  localparam logic [4:0]  OFS_LIVE = 5'h0c;
  localparam logic [4:0]  OFS_PDN  = 5'h10;
  localparam logic [4:0]  OFS_STATE = 5'h14;
  localparam logic [10:0] MASK_RST = 11'h000;
  localparam logic [3:0]  PDN_RST  = 4'hf;
  localparam logic [5:0]  CTRL_RST = 6'h00;
  // ----------------------------------------------------------------
  // control fields: pin polarity, pin drive, rate class, checks
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W    = 6;
  localparam int unsigned INT_POL   = 0;
  localparam int unsigned INT_PP    = 1;
  localparam int unsigned RATE_LSB  = 2;
  localparam int unsigned SP_CHK    = 4;
  localparam int unsigned CLK_CHK   = 5;
  localparam int unsigned ST_MUTED  = 0;
  localparam int unsigned ST_PDNSET = 1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SP_TIMEOUT_NS = 25600;
  localparam int unsigned SP_TIMEOUT_CYC = SP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_W = 16;
endpackage : ceiu_pkg

// ===== include/ceiu_evt_if.sv
// Purpose: carries error levels, clears and sticky flags
// Assumes: single clock domain
// Notes:   onset is a one-cycle pulse per source
`timescale 1ns/100ps
interface ceiu_evt_if #(parameter int unsigned N = 11);
  logic [N-1:0] level;
  logic [N-1:0] clr;
  logic [N-1:0] status;
  logic [N-1:0] onset;
  modport src   (output level, output clr, input status, input onset);
  modport latch (input level, input clr, output status, output onset);
endinterface : ceiu_evt_if

// ===== hdl/ceiu_sync.sv
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   only stage two is visible outside
`timescale 1ns/100ps
module ceiu_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  // ------------------------------------------------------------
  // two stages, first read only by the second
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule : ceiu_sync

// ===== hdl/ceiu_sticky.sv
// Purpose: onset-edge sticky notification bits
// Assumes: levels and clears on the same clock
// Notes:   a set in the clear cycle wins
`timescale 1ns/100ps
module ceiu_sticky #(
  parameter int unsigned N = 11
) (
  input  wire logic clk,
  input  wire logic nrst,
  ceiu_evt_if.latch ev
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] stat_reg;
  logic [N-1:0] stat_next;
  logic [N-1:0] rise;
  // ------------------------------------------------------------
  // per-source onset detect and hold
  // ------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_comb begin
      rise[i]      = ev.level[i] & ~prev_reg[i];
      stat_next[i] = rise[i] | (stat_reg[i] & ~ev.clr[i]);
    end
  end
  // register flags and last level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '0;
      stat_reg <= '0;
    end else begin
      prev_reg <= ev.level;
      stat_reg <= stat_next;
    end
  end
  assign ev.status = stat_reg;
  assign ev.onset  = rise;
endmodule : ceiu_sticky

// ===== hdl/ceiu_top.sv
// Purpose: error latching, masking, mute and interrupt pin of the codec
// Assumes: Avalon-MM slave, byte addresses, one word per register
// Notes:   every bus access answers on its second cycle
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module ceiu_top
  import ceiu_pkg::*;
#(
  parameter logic [ceiu_pkg::WD_W-1:0] SP_TIMEOUT = ceiu_pkg::WD_W'(ceiu_pkg::SP_TIMEOUT_CYC)
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [ceiu_pkg::AW-1:0]  avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [ceiu_pkg::DW-1:0]  avs_writedata,
  output logic      [ceiu_pkg::DW-1:0]  avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     test_mode,
  input  wire logic                     frame_clock,
  input  wire logic                     bit_clock,
  input  wire logic                     pll_locked,
  input  wire logic [1:0]               rate_class_rx,
  input  wire logic [ceiu_pkg::NCH-1:0] adc_overflow,
  input  wire logic [ceiu_pkg::NCH-1:0] dac_clip,
  output logic                          mute_out,
  output logic      [ceiu_pkg::NCH-1:0] power_down_bits,
  output logic                          irq,
  output logic                          int_pin_o,
  output logic                          int_pin_oe
);
  import ceiu_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MS_RUN,
    MS_MUTED,
    MS_PDN_SET
  } ceiu_mute_e;

  ceiu_evt_if #(.N(NSRC)) ev ();

  logic                resp_reg;
  logic                resp_next;
  logic [DW-1:0]       rdata_reg;
  logic [DW-1:0]       rdata_next;
  logic [NSRC-1:0]     mask_reg;
  logic [NSRC-1:0]     mask_next;
  logic [CTRL_W-1:0]   ctrl_reg;
  logic [CTRL_W-1:0]   ctrl_next;
  logic [NCH-1:0]      pdn_reg;
  logic [NCH-1:0]      pdn_next;
  ceiu_mute_e          mst_reg;
  ceiu_mute_e          mst_next;
  logic                mute_reg;
  logic                mute_next;
  logic                irq_reg;
  logic                irq_next;
  logic                pin_o_reg;
  logic                pin_o_next;
  logic                pin_oe_reg;
  logic                pin_oe_next;
  logic [2:0]          pin_sync;
  logic [1:0]          clk_prev_reg;
  logic [1:0]          clk_edge;
  logic [WD_W-1:0]     wd_reg [2];
  logic [WD_W-1:0]     wd_next [2];
  logic [1:0]          wd_dead;
  logic                sp_err;
  logic                clk_err;
  logic                acc;
  logic                wr_acc;
  logic                rd_acc;
  logic                severe_onset;
  logic [NSRC-1:0]     pending;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // frame clock, bit clock and pll lock come from outside
  ceiu_sync #(.W(3)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({pll_locked, bit_clock, frame_clock}),
    .q    (pin_sync)
  );

  // ----------------------------------------------------------------
  // serial clock watchdogs
  // ----------------------------------------------------------------
  // a watchdog per serial clock counts cycles since its last edge
  always_comb begin
    clk_edge = pin_sync[1:0] ^ clk_prev_reg;
  end

  for (genvar c = 0; c < 2; c++) begin : g_wd
    always_comb begin
      if (!ctrl_reg[SP_CHK] || clk_edge[c]) begin
        wd_next[c] = '0;
      end else if (wd_reg[c] != SP_TIMEOUT) begin
        wd_next[c] = wd_reg[c] + WD_W'(1);
      end else begin
        wd_next[c] = wd_reg[c];
      end
      wd_dead[c] = (wd_reg[c] == SP_TIMEOUT);
    end

    // register the counter
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        wd_reg[c] <= '0;
      end else begin
        wd_reg[c] <= wd_next[c];
      end
    end
  end

  // remember synchronised clock levels for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_prev_reg <= '0;
    end else begin
      clk_prev_reg <= pin_sync[1:0];
    end
  end

  // ----------------------------------------------------------------
  // error levels into the sticky bank
  // ----------------------------------------------------------------
  // each source is a live level; the bank latches its onset
  always_comb begin
    sp_err  = ctrl_reg[SP_CHK] & (|wd_dead);
    clk_err = ctrl_reg[CLK_CHK]
            & ((rate_class_rx != ctrl_reg[RATE_LSB +: 2]) | ~pin_sync[2]);
    ev.level                    = '0;
    ev.level[ERR_TEST]          = test_mode;
    ev.level[ERR_SP]            = sp_err;
    ev.level[ERR_CLK]           = clk_err;
    ev.level[ERR_ADC +: NCH]    = adc_overflow;
    ev.level[ERR_DAC +: NCH]    = dac_clip;
  end

  // flags are recorded whatever the mask says
  ceiu_sticky #(.N(NSRC)) u_sticky (
    .clk  (clk),
    .nrst (nrst),
    .ev   (ev.latch)
  );

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // first cycle of a request waits, second cycle completes it
  always_comb begin
    acc             = (avs_read | avs_write) & resp_reg;
    wr_acc          = avs_write & resp_reg;
    rd_acc          = avs_read & resp_reg;
    resp_next       = (avs_read | avs_write) & ~resp_reg;
    avs_waitrequest = (avs_read | avs_write) & ~resp_reg;
  end

  // read data is sampled on the first cycle and stands at completion
  always_comb begin
    rdata_next = rdata_reg;
    if (avs_read && !resp_reg) begin
      rdata_next = '0;
      case (avs_address)
        OFS_STAT:  rdata_next[NSRC-1:0]   = ev.status;
        OFS_MASK:  rdata_next[NSRC-1:0]   = mask_reg;
        OFS_CTRL:  rdata_next[CTRL_W-1:0] = ctrl_reg;
        OFS_LIVE:  rdata_next[NSRC-1:0]   = ev.level;
        OFS_PDN:   rdata_next[NCH-1:0]    = pdn_reg;
        OFS_STATE: begin
          rdata_next[ST_MUTED]  = mute_reg;
          rdata_next[ST_PDNSET] = (mst_reg == MS_PDN_SET);
        end
        default:   rdata_next = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // write-one-to-clear on flags; set wins inside the sticky bank
  always_comb begin
    ev.clr = '0;
    if (wr_acc && avs_address == OFS_STAT) begin
      ev.clr = avs_writedata[NSRC-1:0];
    end
  end

  // mask: written by software, auto-set by a flag read
  always_comb begin
    mask_next = mask_reg;
    if (wr_acc && avs_address == OFS_MASK) begin
      mask_next = avs_writedata[NSRC-1:0];
    end else if (rd_acc && avs_address == OFS_STAT) begin
      mask_next = mask_reg | rdata_reg[NSRC-1:0];
    end
  end

  // control and power-down registers
  always_comb begin
    ctrl_next = ctrl_reg;
    pdn_next  = pdn_reg;
    if (wr_acc && avs_address == OFS_CTRL) begin
      ctrl_next = avs_writedata[CTRL_W-1:0];
    end
    if (wr_acc && avs_address == OFS_PDN) begin
      pdn_next = avs_writedata[NCH-1:0];
    end
  end

  // register bus state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp_reg  <= 1'b0;
      rdata_reg <= '0;
      mask_reg  <= MASK_RST;
      ctrl_reg  <= CTRL_RST;
      pdn_reg   <= PDN_RST;
    end else begin
      resp_reg  <= resp_next;
      rdata_reg <= rdata_next;
      mask_reg  <= mask_next;
      ctrl_reg  <= ctrl_next;
      pdn_reg   <= pdn_next;
    end
  end

  // ----------------------------------------------------------------
  // mute and recovery
  // ----------------------------------------------------------------
  // only serial and clocking errors mute; others leave audio running
  always_comb begin
    severe_onset = ev.onset[ERR_SP] | ev.onset[ERR_CLK];
    mst_next     = mst_reg;
    case (mst_reg)
      MS_RUN: begin
        if (severe_onset) begin
          mst_next = MS_MUTED;
        end
      end
      MS_MUTED: begin
        if (severe_onset) begin
          mst_next = MS_MUTED;
        end else if (pdn_reg == {NCH{1'b1}}) begin
          mst_next = MS_PDN_SET;
        end
      end
      MS_PDN_SET: begin
        if (severe_onset) begin
          mst_next = MS_MUTED;
        end else if (pdn_reg == '0) begin
          mst_next = MS_RUN;
        end
      end
      default: mst_next = MS_RUN;
    endcase
    mute_next = (mst_next != MS_RUN);
  end

  // register the recovery state and the mute level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mst_reg  <= MS_RUN;
      mute_reg <= 1'b0;
    end else begin
      mst_reg  <= mst_next;
      mute_reg <= mute_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt line
  // ----------------------------------------------------------------
  // pending = recorded and unmasked; the pin follows polarity and drive
  always_comb begin
    pending  = ev.status & ~mask_reg;
    irq_next = |pending;
    if (ctrl_reg[INT_PP]) begin
      pin_o_next  = ctrl_reg[INT_POL] ? irq_next : ~irq_next;
      pin_oe_next = 1'b1;
    end else if (ctrl_reg[INT_POL]) begin
      pin_o_next  = 1'b0;
      pin_oe_next = ~irq_next;
    end else begin
      pin_o_next  = 1'b0;
      pin_oe_next = irq_next;
    end
  end

  // register the interrupt outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg    <= 1'b0;
      pin_o_reg  <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      irq_reg    <= irq_next;
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = rdata_reg;
  assign mute_out        = mute_reg;
  assign power_down_bits = pdn_reg;
  assign irq             = irq_reg;
  assign int_pin_o       = pin_o_reg;
  assign int_pin_oe      = pin_oe_reg;

endmodule : ceiu_top

// ===== sim/ceiu_int_line.sv
// Purpose: interrupt net as the system controller sees it
// Assumes: pull-up resistor on the shared net
// Notes:   a released net reads high
`timescale 1ns/100ps
module ceiu_int_line (
  input  wire logic int_pin_o,
  input  wire logic int_pin_oe,
  output logic      line
);
  // pull-up sets the level while the pin is released
  assign line = int_pin_oe ? int_pin_o : 1'b1;
endmodule : ceiu_int_line

// ===== sim/ceiu_checker.sv
// Purpose: port checks of the codec error interrupt unit
// Assumes: one clock, nrst asynchronous active low
// Notes:   bound to ceiu_top below
`timescale 1ns/100ps
module ceiu_checker
  import ceiu_pkg::*;
#(
  parameter logic [ceiu_pkg::WD_W-1:0] SP_TIMEOUT = 16'h0008
) (
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire logic [ceiu_pkg::AW-1:0]  avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [ceiu_pkg::DW-1:0]  avs_writedata,
  input wire logic [ceiu_pkg::DW-1:0]  avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire logic                     test_mode,
  input wire logic                     frame_clock,
  input wire logic                     bit_clock,
  input wire logic                     pll_locked,
  input wire logic [1:0]               rate_class_rx,
  input wire logic [ceiu_pkg::NCH-1:0] adc_overflow,
  input wire logic [ceiu_pkg::NCH-1:0] dac_clip,
  input wire logic                     mute_out,
  input wire logic [ceiu_pkg::NCH-1:0] power_down_bits,
  input wire logic                     irq,
  input wire logic                     int_pin_o,
  input wire logic                     int_pin_oe
);
  // ----
  // bus steps
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence req_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  sequence stat_rd_done;
    req_done ##0 avs_read && avs_address == OFS_STAT && adc_overflow == 4'h0
      && dac_clip == 4'h0 && !test_mode;
  endsequence
  // ----
  // assertions
  // ----
  wait_one_a: assert property (req_wait |=> !avs_waitrequest || !(avs_read || avs_write))
    else $error("request waited more than one cycle");
  wait_again_a: assert property (req_done |=> avs_waitrequest || !(avs_read || avs_write))
    else $error("next request was not held for a wait cycle");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed outside a read");
  auto_mask_a: assert property (stat_rd_done |=> ##1 !irq)
    else $error("irq stayed high after the status read");
  irq_fall_a: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest, 2)
    || $past(avs_read && !avs_waitrequest && avs_address == OFS_STAT, 2))
    else $error("irq dropped without a bus access");
  pdn_write_a: assert property ($changed(power_down_bits)
    |-> $past(avs_write && !avs_waitrequest && avs_address == OFS_PDN))
    else $error("power down bits changed without a write");
  unmute_a: assert property ($fell(mute_out) |-> $past(power_down_bits) == 4'h0)
    else $error("mute released before power down cleared");
  pin_od_a: assert property (int_pin_o |-> int_pin_oe)
    else $error("pin drives high while disabled");
  pin_track_a: assert property ($changed(irq) |-> $changed({int_pin_o, int_pin_oe}))
    else $error("pin did not follow irq");
endmodule : ceiu_checker
bind ceiu_top ceiu_checker #(.SP_TIMEOUT(SP_TIMEOUT)) ceiu_checker_inst (
  .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .test_mode(test_mode), .frame_clock(frame_clock),
  .bit_clock(bit_clock), .pll_locked(pll_locked), .rate_class_rx(rate_class_rx),
  .adc_overflow(adc_overflow), .dac_clip(dac_clip), .mute_out(mute_out),
  .power_down_bits(power_down_bits), .irq(irq), .int_pin_o(int_pin_o),
  .int_pin_oe(int_pin_oe));

// ===== sim/testbench.sv
// Purpose: register level tests of the codec error interrupt unit
// Assumes: short serial watchdog of 8 cycles
// Notes:   serial clocks run only while run is set
`timescale 1ns/100ps
module testbench;
  import ceiu_pkg::*;
  logic        clk, nrst, rd, wr, tm, fck, bck, lock, wq, irq, mute, po, poe, line, run;
  logic [4:0]  ad;
  logic [31:0] wd, rdat, v;
  logic [1:0]  rc;
  logic [3:0]  adc, dac, pdn;
  int          mismatches, checks, i;
  ceiu_top #(.SP_TIMEOUT(16'h0008)) ceiu_top_inst (.clk(clk), .nrst(nrst),
    .avs_address(ad), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wq), .test_mode(tm), .frame_clock(fck),
    .bit_clock(bck), .pll_locked(lock), .rate_class_rx(rc), .adc_overflow(adc),
    .dac_clip(dac), .mute_out(mute), .power_down_bits(pdn), .irq(irq),
    .int_pin_o(po), .int_pin_oe(poe));
  ceiu_int_line ceiu_int_line_inst (.int_pin_o(po), .int_pin_oe(poe), .line(line));
  // ----
  // clock, serial clocks, tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // serial clocks toggle each cycle while running
  always @(posedge clk) begin
    if (run) begin
      fck <= ~fck;
      bck <= ~bck;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one bus access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    ad <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      mismatches++;
      report_and_stop();
    end else begin
      v = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask : bus
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wreg
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // drives one error source by its status bit index
  task automatic src(input int k, input logic b);
    @(posedge clk);
    if (k == 0) tm <= b;
    else if (k < 7) adc[k-3] <= b;
    else dac[k-7] <= b;
  endtask : src
  // ----
  // main sequence
  // ----
  initial begin
    {nrst, rd, wr, tm, fck, bck, run, ad, wd, adc, dac, rc} = '0;
    lock = 1'b1;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rchk(OFS_STAT, 32'h0);
    rchk(OFS_MASK, 32'h0);
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_PDN, 32'hf);
    rchk(5'h1c, 32'h0);
    cyc(1);
    chk({irq, mute, line}, 3'h1);
    $display("test reset done");
    src(3, 1'b1);
    src(3, 1'b0);
    cyc(4);
    chk({irq, line, mute}, 3'h4);
    rchk(OFS_STAT, 32'h8);
    cyc(2);
    chk(irq, 32'h0);
    rchk(OFS_MASK, 32'h8);
    wreg(OFS_STAT, 32'h8);
    src(3, 1'b1);
    src(3, 1'b0);
    cyc(4);
    chk(irq, 32'h0);
    rchk(OFS_STAT, 32'h8);
    wreg(OFS_MASK, 32'h0);
    cyc(2);
    chk(irq, 32'h1);
    wreg(OFS_STAT, 32'h8);
    cyc(2);
    chk(irq, 32'h0);
    src(4, 1'b1);
    cyc(4);
    wreg(OFS_STAT, 32'h10);
    cyc(4);
    rchk(OFS_STAT, 32'h0);
    src(4, 1'b0);
    $display("test sticky done");
    for (i = 0; i < 11; i++) begin
      if (i == 1 || i == 2) continue;
      src(i, 1'b1);
      src(i, 1'b0);
      cyc(3);
      chk(mute, 32'h0);
      rchk(OFS_STAT, 32'h1 << i);
      wreg(OFS_STAT, 32'h7ff);
      wreg(OFS_MASK, 32'h0);
    end
    $display("test sources done");
    src(10, 1'b1);
    src(10, 1'b0);
    for (i = 0; i < 8; i++) begin
      if (i == 4) wreg(OFS_STAT, 32'h7ff);
      wreg(OFS_CTRL, i % 4);
      cyc(2);
      chk({po, poe}, i[1] ? {i[0] ~^ ~i[2], 1'b1} : {1'b0, i[0] ^ ~i[2]});
    end
    $display("test pin done");
    @(posedge clk);
    rc <= 2'h1;
    wreg(OFS_CTRL, 32'h24);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      if (i == 0) rc <= 2'h2;
      else lock <= 1'b0;
      cyc(6);
      chk(mute, 32'h1);
      rchk(OFS_STAT, 32'h4);
      rchk(OFS_LIVE, 32'h4);
      @(posedge clk);
      rc <= 2'h1;
      lock <= 1'b1;
      cyc(4);
      wreg(OFS_STAT, 32'h7ff);
      wreg(OFS_PDN, 32'hf);
      rchk(OFS_STATE, 32'h3);
      wreg(OFS_PDN, 32'h0);
      cyc(2);
      chk({mute, pdn}, 32'h0);
      wreg(OFS_MASK, 32'h0);
    end
    $display("test clocking done");
    @(posedge clk);
    run <= 1'b1;
    wreg(OFS_CTRL, 32'h10);
    cyc(20);
    chk(mute, 32'h0);
    @(posedge clk);
    run <= 1'b0;
    cyc(16);
    chk(mute, 32'h1);
    rchk(OFS_STAT, 32'h2);
    rchk(OFS_STATE, 32'h1);
    @(posedge clk);
    run <= 1'b1;
    cyc(4);
    wreg(OFS_STAT, 32'h7ff);
    wreg(OFS_PDN, 32'hf);
    wreg(OFS_PDN, 32'h0);
    cyc(2);
    chk(mute, 32'h0);
    $display("test serial done");
    report_and_stop();
  end
endmodule : testbench
